/* File: core/hav_map.svh */
// Offsets, field layout, reset values and widths of the averaging stage.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HAV_MAP_SVH
`define HAV_MAP_SVH

`define HAV_CTRL_OFFSET   12'h000
`define HAV_STAT_OFFSET   12'h004
`define HAV_ADDR_W        12
`define HAV_CTRL_RESET    32'h0000_0000
`define HAV_CTRL_RW_MASK  32'h7777_7777
`define HAV_FLD_STRIDE    4
`define HAV_FLD_W         3
`define HAV_NUM_CH        8
`define HAV_CHAN_W        3
`define HAV_DATA_W        12
`define HAV_MAX_SHIFT     6
`define HAV_ACC_W         18
`define HAV_CNT_W         6
`define HAV_STAT_PART_LSB 0
`define HAV_STAT_CNT_LSB  16
`define HAV_STAT_CNT_W    16
`define HAV_SEL_PASS      3'h0
`define HAV_SEL_RSVD      3'h7
`define HAV_RESP_OKAY     2'h0
`define HAV_RESP_SLVERR   2'h2

`endif

/* File: core/hav_pkg.sv */
// Types shared by the averaging stage and its bench.
// Assumes hav_map.svh is on the include path.
`default_nettype none
`include "hav_map.svh"

package hav_pkg;

	typedef logic [`HAV_FLD_W-1:0]  hav_sel_t;
	typedef logic [`HAV_DATA_W-1:0] hav_data_t;

	// One conversion or one result, tagged with its channel
	typedef struct packed {
		logic [`HAV_CHAN_W-1:0] chan;
		hav_data_t              data;
	} hav_sample_t;

endpackage

`default_nettype wire

/* File: core/hav_accum.sv */
// One channel's accumulator: sums 2^n conversions, emits the shifted sum.
// Assumes in_valid is high only for conversions of this channel.
`default_nettype none
`include "hav_map.svh"

module hav_accum (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire hav_pkg::hav_sel_t  sel,
	input  wire logic              in_valid,
	input  wire hav_pkg::hav_data_t in_data,
	output logic                   done,
	output hav_pkg::hav_data_t      result,
	output logic                   partial
);
	import hav_pkg::*;

	logic [`HAV_ACC_W-1:0] acc_q;
	logic [`HAV_CNT_W-1:0] cnt_q;
	logic [`HAV_ACC_W-1:0] sum;
	logic [`HAV_CNT_W-1:0] last_idx;
	logic                  pass;

	always_comb begin
		// Reserved code 7 is treated as pass-through
		pass     = (sel == `HAV_SEL_PASS) || (sel == `HAV_SEL_RSVD); // [RULE4]
		sum      = acc_q + {{(`HAV_ACC_W-`HAV_DATA_W){1'b0}}, in_data};
		last_idx = `HAV_CNT_W'(({1'b0, {`HAV_CNT_W{1'b0}}} + 7'h01 << sel)
			- 7'h01); // [RULE5] [RULE6]
		done     = in_valid && (pass || cnt_q >= last_idx);
		result   = pass ? in_data : `HAV_DATA_W'(sum >> sel); // [RULE8]
		partial  = (cnt_q != '0);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= '0;
			cnt_q <= '0;
		end else if (ce && in_valid) begin
			if (done) begin
				acc_q <= '0; // [RULE8]
				cnt_q <= '0;
			end else begin
				acc_q <= sum; // [RULE8]
				cnt_q <= cnt_q + `HAV_CNT_W'(1);
			end
		end
	end

endmodule // hav_accum

`default_nettype wire

/* File: core/hav_averager.sv */
// Per-channel hardware averaging stage with an AXI4-Lite control slave.
// Assumes conversions arrive one per s_valid pulse, synchronous to aclk,
// and that the sequencer FIFO downstream takes every m_valid pulse.
//
// Summary of operation
// RULE1: Each channel averages on its own, using its own setting.
// RULE2: Control register holds eight 3-bit fields, channel k at bits 4k+2:4k.
// RULE3: Bits 31,27,...,3 are reserved, read zero, ignore writes.
// RULE4: Setting zero forwards each conversion unchanged.
// RULE5: Setting n (1..6) averages 2^n conversions into one result.
// RULE6: Settings 1..5 select 2x, 4x, 8x, 16x, 32x oversampling.
// RULE7: Software must not program setting 7; result undefined.
// RULE8: Accumulate 2^n conversions, shift right n, clear for next group.
`default_nettype none
`include "hav_map.svh"

module hav_averager (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   ce,
	// Converter side
	input  wire logic                   s_valid,
	input  wire hav_pkg::hav_sample_t   s_sample,
	// Sequencer FIFO side
	output logic                        m_valid,
	output hav_pkg::hav_sample_t        m_sample,
	// AXI4-Lite slave
	input  wire logic [`HAV_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`HAV_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);
	import hav_pkg::*;

	logic [31:0]                  ctrl_q;
	logic [`HAV_STAT_CNT_W-1:0]   res_cnt_q;
	logic                         aw_got_q;
	logic                         w_got_q;
	logic [`HAV_ADDR_W-1:0]       awaddr_q;
	logic [31:0]                  wdata_q;
	logic [3:0]                   wstrb_q;
	logic                         commit;
	logic [31:0]                  wmask;
	logic [31:0]                  stat_word;
	logic [`HAV_NUM_CH-1:0]       ch_done;
	logic [`HAV_NUM_CH-1:0]       ch_part;
	hav_data_t                    ch_res [`HAV_NUM_CH];
	hav_data_t                    res_d;
	logic                         any_done;

	// Per-channel accumulators
	for (genvar k = 0; k < `HAV_NUM_CH; k++) begin : g_ch
		hav_accum u_accum (
			.aclk     (aclk),
			.aresetn  (aresetn),
			.ce       (ce),
			.sel      (ctrl_q[`HAV_FLD_STRIDE*k +: `HAV_FLD_W]), // [RULE1]
			.in_valid (s_valid &&
				s_sample.chan == `HAV_CHAN_W'(k)), // [RULE1]
			.in_data  (s_sample.data),
			.done     (ch_done[k]),
			.result   (ch_res[k]),
			.partial  (ch_part[k])
		);
	end

	always_comb begin
		any_done = |ch_done;
		res_d    = ch_res[s_sample.chan];
	end

	// Result towards the sequencer FIFO, one per finished group
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			m_valid  <= 1'b0;
			m_sample <= '0;
		end else if (ce) begin
			m_valid <= any_done; // [RULE5]
			if (any_done) begin
				m_sample.chan <= s_sample.chan;
				m_sample.data <= res_d; // [RULE4] [RULE5]
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_cnt_q <= '0;
		end else if (ce && any_done) begin
			res_cnt_q <= res_cnt_q + `HAV_STAT_CNT_W'(1);
		end
	end

	// Write channel: address and data in either order, then one response
	always_comb begin
		commit = aw_got_q && w_got_q && !s_axi_bvalid;
		for (int b = 0; b < 4; b++) begin
			wmask[8*b +: 8] = {8{wstrb_q[b]}};
		end
		wmask = wmask & `HAV_CTRL_RW_MASK; // [RULE3]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			awaddr_q      <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q      <= 1'b1;
				s_axi_awready <= 1'b0;
				awaddr_q      <= s_axi_awaddr;
			end else if (commit) begin
				aw_got_q <= 1'b0;
			end else if (!aw_got_q && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_q      <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q      <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
			end else if (commit) begin
				w_got_q <= 1'b0;
			end else if (!w_got_q && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `HAV_RESP_OKAY;
		end else if (ce) begin
			if (commit) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == `HAV_CTRL_OFFSET ||
					awaddr_q == `HAV_STAT_OFFSET) ?
					`HAV_RESP_OKAY : `HAV_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Averaging settings; reserved bits never stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `HAV_CTRL_RESET; // [RULE2]
		end else if (ce && commit && awaddr_q == `HAV_CTRL_OFFSET) begin
			ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask); // [RULE2] [RULE3]
		end
	end

	// Read channel
	always_comb begin
		stat_word = '0;
		stat_word[`HAV_STAT_PART_LSB +: `HAV_NUM_CH] = ch_part;
		stat_word[`HAV_STAT_CNT_LSB +: `HAV_STAT_CNT_W] = res_cnt_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `HAV_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `HAV_RESP_OKAY;
				unique case (s_axi_araddr)
					`HAV_CTRL_OFFSET: s_axi_rdata <= ctrl_q & `HAV_CTRL_RW_MASK; // [RULE3]
					`HAV_STAT_OFFSET: s_axi_rdata <= stat_word;
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= `HAV_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // hav_averager

`default_nettype wire

/* File: bench/hav_averager_monitor.sv */
// Assertion checker for the averaging stage.
// Assumes binding to hav_averager; sees its ports only.
`default_nettype none

module hav_averager_monitor (
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire logic                 ce,
	input wire logic                 s_valid,
	input wire hav_pkg::hav_sample_t s_sample,
	input wire logic                 m_valid,
	input wire hav_pkg::hav_sample_t m_sample,
	input wire logic                 s_axi_bvalid,
	input wire logic                 s_axi_bready,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic [31:0]          s_axi_rdata,
	input wire logic [1:0]           s_axi_rresp,
	input wire logic                 s_axi_rvalid,
	input wire logic                 s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_res_cause: assert property (m_valid && $past(ce) |->
		$past(s_valid)) else $error("result without a sample");
	chk_res_chan: assert property (m_valid && $past(ce) |->
		m_sample.chan == $past(s_sample.chan)) else $error("bad channel");
	chk_res_hold: assert property (!m_valid |->
		$stable(m_sample)) else $error("result moved");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("write response dropped");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready
		&& ce |=> s_axi_rvalid) else $error("read not answered");
	chk_err_zero: assert property (s_axi_rvalid &&
		s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read not zero");

	cover property (m_valid);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule // hav_averager_monitor

bind hav_averager hav_averager_monitor u_mon (.*);

`default_nettype wire

/* File: bench/hav_conv_model.sv */
// Converter and sequencer FIFO stand-in for the averaging stage.
// Assumes send is called just after a rising edge of aclk.
`default_nettype none

module hav_conv_model (
	output logic                     s_valid,
	output hav_pkg::hav_sample_t     s_sample,
	input wire logic                 aclk,
	input wire logic                 m_valid,
	input wire hav_pkg::hav_sample_t m_sample
);
	timeunit 1ns;
	timeprecision 1ps;
	import hav_pkg::*;
	hav_sample_t got[$];

	initial begin
		s_valid = 1'b0;
		s_sample = '0;
	end

	// One conversion per call; valid stays up for a back-to-back send
	task automatic send(input logic [2:0] c, input hav_data_t d);
		s_valid <= 1'b1;
		s_sample <= {c, d};
		@(posedge aclk);
	endtask

	// Idle the link, data inverted while not valid, then let n edges pass
	task automatic rest(input int n);
		s_valid <= 1'b0;
		s_sample <= ~s_sample;
		repeat (n) @(posedge aclk);
	endtask

	always @(posedge aclk) if (m_valid) got.push_back(m_sample);
endmodule // hav_conv_model

`default_nettype wire

/* File: bench/tb_hav_averager.sv */
// Self-checking bench for the averaging stage.
// Assumes the bound monitor and the converter model beside the design.
`default_nettype none

module tb_hav_averager;
	timeunit 1ns;
	timeprecision 1ps;
	import hav_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, s_valid, m_valid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	hav_sample_t s_sample, m_sample;
	int          err_count = 0, checks = 0, cyc = 0;
	logic        ce = 1'b1;

	hav_averager dut (.*);
	hav_conv_model cm (.*);

	initial forever #2 aclk = ~aclk;

	task automatic wrap_up;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic cmp(input logic [31:0] g, e, input string m);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	task automatic cmp_res(input logic [2:0] c, input int e);
		hav_sample_t g;
		g = cm.got.size() ? cm.got.pop_front() : 'x;
		cmp(32'(g), 32'({c, 12'(e)}), "result");
	endtask

	task automatic wr(input logic [31:0] d, input logic [3:0] s);
		s_axi_awaddr <= 12'h000;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		cmp(32'(s_axi_bresp), 32'h0, "bresp");
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		cmp(s_axi_rdata, e, "rdata");
		cmp(32'(s_axi_rresp), 32'(r), "rresp");
	endtask

	// Setting 7 is never programmed anywhere below
	task automatic t_regs;
		rd(12'h000, 32'h0, 2'h0);
		wr(32'hEEEEEEEE, 4'h1);
		rd(12'h000, 32'h00000066, 2'h0);
		wr(32'hEEEEEEEE, 4'hF);
		rd(12'h000, 32'h66666666, 2'h0);
		rd(12'h010, 32'h0, 2'h2);
		wr(32'h0, 4'hF);
	endtask

	task automatic t_pass;
		cm.send(3'h3, 12'hA5C);
		cm.send(3'h3, 12'h123);
		cm.rest(2);
		cmp_res(3'h3, 12'hA5C);
		cmp_res(3'h3, 12'h123);
	endtask

	task automatic t_avg;
		int s;
		for (int n = 1; n <= 6; n++) begin
			wr(32'(n) << (4 * n), 4'hF);
			for (int g = 0; g < 2; g++) begin
				s = 0;
				for (int i = 0; i < (1 << n); i++) begin
					s += 4000 - 37 * i - 100 * g;
					cm.send(3'(n), 12'(4000 - 37 * i - 100 * g));
				end
				cm.rest(2);
				cmp_res(3'(n), s >> n);
				cmp(32'(cm.got.size()), 32'h0, "extra");
			end
		end
	endtask

	task automatic t_mix;
		wr(32'h00000001, 4'hF);
		cm.send(3'h0, 12'h00A);
		cm.send(3'h1, 12'h007);
		cm.send(3'h0, 12'h00D);
		cm.rest(2);
		cmp_res(3'h1, 12'h007);
		cmp_res(3'h0, 12'h00B);
	endtask

	// Clock enable low: a conversion must leave no result behind
	task automatic t_hold;
		ce <= 1'b0;
		cm.send(3'h2, 12'h0F0);
		cm.rest(2);
		cmp(32'(cm.got.size()), 32'h0, "frozen");
		ce <= 1'b1;
		cm.send(3'h2, 12'h0F0);
		cm.rest(2);
		cmp_res(3'h2, 12'h0F0);
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_pass();
		t_avg();
		t_mix();
		t_hold();
		wrap_up();
	end
endmodule // tb_hav_averager

`default_nettype wire
